// File: logic/mcs_pkg.sv
// package: register map, codes, timing and carriers of the memory config block
package mcs_pkg;
  localparam logic [7:0] OFS_GATING = 8'h00;
  localparam logic [7:0] OFS_MAPPING = 8'h04;
  localparam logic [7:0] OFS_IDENT_A = 8'h08;
  localparam logic [7:0] OFS_IDENT_B = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_PRI_PROT = 8'h14;
  localparam logic [7:0] OFS_BOOT_PROT = 8'h18;
  localparam logic [7:0] GATING_MASK = 8'h7D;
  localparam logic [7:0] MAPPING_MASK = 8'h9F;
  localparam logic [7:0] BOOT_PROT_MASK = 8'h0F;
  localparam logic [7:0] GATING_RST = 8'h00;
  localparam logic [7:0] PROT_RST = 8'h00;
  localparam logic [3:0] MAP_CFG_RST = 4'h0;
  localparam int GT_ADDR_BIT = 0;
  localparam int GT_CNTL_LSB = 2;
  localparam int GT_ALE_BIT = 5;
  localparam int GT_WRH_BIT = 6;
  localparam int MAP_PERIPH_BIT = 7;
  localparam int ST_REFUSED_BIT = 4;
  localparam logic [3:0] PRI_SIZE_CODE = 4'h5;
  localparam logic [3:0] SRAM_SIZE_CODE = 4'h3;
  localparam logic [3:0] SEC_SIZE_CODE = 4'h2;
  localparam logic [1:0] SEC_TYPE_CODE = 2'h0;
  localparam int PRI_SECTORS = 8;
  localparam int BOOT_SECTORS = 4;
  localparam int TERMS = 3;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'hAAA;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h554;
  localparam logic [7:0] CODE_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_PROGRAM = 8'hA0;
  localparam logic [7:0] CODE_ERASE = 8'h80;
  localparam logic [7:0] CODE_SECTOR = 8'h30;
  localparam logic [7:0] CODE_BULK = 8'h10;
  localparam logic [7:0] CODE_SUSPEND = 8'hB0;
  localparam logic [7:0] CODE_IDENT = 8'h90;
  localparam logic [7:0] CODE_RESET = 8'hF0;
  localparam int CLK_MHZ = 100;
  localparam int SE_WINDOW_US = 80;
  localparam int SE_WINDOW_CYC = SE_WINDOW_US * CLK_MHZ;
  localparam int BYTE_TIMEOUT_CYC = 1000;
  localparam int PROG_CYC = 1000;
  localparam int ERASE_CYC = 20000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    FS_READ, FS_UNL1, FS_UNL2, FS_PROG_DATA, FS_ERS_CMD, FS_ERS_UNL1,
    FS_ERS_UNL2, FS_SE_WIN, FS_BUSY, FS_SUSP, FS_IDENT
  } mcs_flash_state_t;
  typedef struct packed {
    logic [7:0] low_addr;
    logic [2:0] bus_control_inputs;
    logic ale;
    logic high_byte_write_strobe;
    logic [3:0] port_f_low_pins;
    logic [3:0] muxed_bus_upper_nibble;
    logic program_store_strobe_n;
    logic separate_space_mode;
  } mcs_pins_t;
  typedef struct packed {
    logic [7:0] low_address_gate;
    logic [2:0] bus_control_inputs;
    logic ale;
    logic high_byte_write_strobe;
  } mcs_array_in_t;
  typedef struct packed {
    logic primary_data_access;
    logic boot_data_access;
    logic primary_program_access;
    logic boot_program_access;
    logic sram_program_access;
  } mcs_access_t;
endpackage

// File: logic/mcs_memory_config.sv
// memory configuration registers, sector selects and flash command engine
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - gating bit 0 high blocks the low eight address lines from the array.
// - separate-space mode: low address from port F and bus upper nibble.
// - gating bits 4..2 disconnect the three bus control inputs when high.
// - gating bit 5 disconnects the address latch enable when high.
// - gating bit 6 disconnects the high-byte write strobe when high.
// - reset loads mapping bits 4..1 from config, clears bits 0, 7.
// - mapping bits 4..0 act only in separate-space mode.
// - mapping bit 0 lets program strobe cycles reach the SRAM.
// - mapping bit 1 low blocks program strobe cycles to the secondary memory.
// - mapping bit 7 enables port F peripheral mode.
// - ident A bits 3..0 give the primary flash size code.
// - ident A bits 7..4 give the SRAM size code.
// - ident B bits 3..0 give the secondary memory size code.
// - ident B bits 5..4 give the secondary memory type.
// - primary flash has eight sector selects, SRAM one select.
// - secondary flash has four boot sector selects.
// - each sector can be protected; program or erase on it is refused.
// - each sector select is the OR of up to three product terms.
// - ready/busy is low during program or erase, high otherwise.
// - plain writes never alter flash; only command sequences do.
// - a sector erase may be suspended and later resumed.
// - every command opens with AAh at AAAh then 55h at 554h, except suspend (B0h), resume (30h) and the F0h ident exit.
// - a bad byte or byte time-out inside a command sequence returns to read mode; suspend and ident mode ignore other bytes.
module mcs_memory_config #(
  parameter logic [3:0] USER_MAP_CFG = mcs_pkg::MAP_CFG_RST,
  parameter logic [3:0] PRI_SIZE = mcs_pkg::PRI_SIZE_CODE,
  parameter logic [3:0] SRAM_SIZE = mcs_pkg::SRAM_SIZE_CODE,
  parameter logic [3:0] SEC_SIZE = mcs_pkg::SEC_SIZE_CODE,
  parameter logic [1:0] SEC_TYPE = mcs_pkg::SEC_TYPE_CODE,
  parameter int unsigned SE_WINDOW = mcs_pkg::SE_WINDOW_CYC,
  parameter int unsigned BYTE_TIMEOUT = mcs_pkg::BYTE_TIMEOUT_CYC,
  parameter int unsigned PROG_TIME = mcs_pkg::PROG_CYC,
  parameter int unsigned ERASE_TIME = mcs_pkg::ERASE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire mcs_pkg::mcs_pins_t pins_in,
  input wire logic [mcs_pkg::PRI_SECTORS*mcs_pkg::TERMS-1:0] pri_terms,
  input wire logic [mcs_pkg::BOOT_SECTORS*mcs_pkg::TERMS-1:0] boot_terms,
  input wire logic [mcs_pkg::TERMS-1:0] sram_terms,
  input wire logic flash_wr,
  input wire logic [11:0] flash_addr,
  input wire logic [7:0] flash_data,
  output mcs_pkg::mcs_array_in_t array_in,
  output mcs_pkg::mcs_access_t access_en,
  output logic sram_program_strobe,
  output logic boot_program_strobe,
  output logic port_f_peripheral_en,
  output logic [mcs_pkg::PRI_SECTORS-1:0] primary_sector_selects,
  output logic [mcs_pkg::BOOT_SECTORS-1:0] boot_sector_selects,
  output logic sram_select,
  output logic ready_busy_pin
);
  localparam int NSEC = mcs_pkg::PRI_SECTORS + mcs_pkg::BOOT_SECTORS;
  localparam int PW = $bits(mcs_pkg::mcs_pins_t);

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= mcs_pkg::OFS_BOOT_PROT);
  endfunction

  function automatic logic is_cmd(input logic [11:0] a, input logic [7:0] d,
                                  input logic [11:0] ea, input logic [7:0] ed);
    is_cmd = (a == ea) && (d == ed);
  endfunction

  // pin synchroniser; first stage feeds only the second
  logic [PW-1:0] meta_q;
  logic [PW-1:0] sync_q;
  mcs_pkg::mcs_pins_t pins;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins_in;
      sync_q <= meta_q;
    end
  end
  assign pins = sync_q;

  // strap caught once the synchroniser is full
  logic [1:0] strap_cnt_q;
  logic sep_mode_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt_q <= 2'h0;
      sep_mode_q <= 1'b0;
    end else if (strap_cnt_q != 2'h3) begin
      strap_cnt_q <= strap_cnt_q + 2'h1;
      if (strap_cnt_q == 2'h2) begin
        sep_mode_q <= pins.separate_space_mode;
      end
    end
  end

  logic [7:0] gating_q;
  logic [7:0] mapping_q;
  logic [7:0] pri_prot_q;
  logic [3:0] boot_prot_q;
  logic refused_q;
  logic refuse_ev;
  logic [7:0] ident_a;
  logic [7:0] ident_b;
  logic [7:0] status;
  mcs_pkg::mcs_flash_state_t state_q;

  assign ident_a = {SRAM_SIZE, PRI_SIZE};
  assign ident_b = {2'h0, SEC_TYPE, SEC_SIZE};
  assign status = {3'h0, refused_q, sep_mode_q, state_q == mcs_pkg::FS_IDENT,
                   state_q == mcs_pkg::FS_SUSP, state_q == mcs_pkg::FS_BUSY};

  // axi write: aw and w in either order
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] waddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      waddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= mcs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        waddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(waddr_q) ? mcs_pkg::RESP_OKAY : mcs_pkg::RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  logic wr_en;
  assign wr_en = do_write && wlane_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gating_q <= mcs_pkg::GATING_RST;
      mapping_q <= {3'h0, USER_MAP_CFG, 1'b0};
    end else if (wr_en) begin
      if (waddr_q == mcs_pkg::OFS_GATING) begin
        gating_q <= wdata_q & mcs_pkg::GATING_MASK;
      end
      if (waddr_q == mcs_pkg::OFS_MAPPING) begin
        mapping_q <= wdata_q & mcs_pkg::MAPPING_MASK;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pri_prot_q <= mcs_pkg::PROT_RST;
      boot_prot_q <= 4'h0;
    end else if (wr_en) begin
      if (waddr_q == mcs_pkg::OFS_PRI_PROT) begin
        pri_prot_q <= wdata_q;
      end
      if (waddr_q == mcs_pkg::OFS_BOOT_PROT) begin
        boot_prot_q <= wdata_q[3:0];
      end
    end
  end

  // refused flag: a new refusal wins over a same-cycle clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      refused_q <= 1'b0;
    end else if (refuse_ev) begin
      refused_q <= 1'b1;
    end else if (wr_en && waddr_q == mcs_pkg::OFS_STATUS &&
                 wdata_q[mcs_pkg::ST_REFUSED_BIT]) begin
      refused_q <= 1'b0;
    end
  end

  // axi read path
  logic rvalid_q;
  logic [7:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] rmux;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = {24'h000000, rdata_q};
  assign s_axi_rresp = rresp_q;

  always_comb begin
    case (s_axi_araddr)
      mcs_pkg::OFS_GATING: rmux = gating_q;
      mcs_pkg::OFS_MAPPING: rmux = mapping_q;
      mcs_pkg::OFS_IDENT_A: rmux = ident_a;
      mcs_pkg::OFS_IDENT_B: rmux = ident_b;
      mcs_pkg::OFS_STATUS: rmux = status;
      mcs_pkg::OFS_PRI_PROT: rmux = pri_prot_q;
      mcs_pkg::OFS_BOOT_PROT: rmux = {4'h0, boot_prot_q};
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= mcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rmux;
      rresp_q <= is_mapped(s_axi_araddr) ? mcs_pkg::RESP_OKAY : mcs_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // sector selects from product terms
  logic [NSEC-1:0] sel;
  logic [NSEC-1:0] prot;
  genvar g;
  generate
    for (g = 0; g < NSEC; g++) begin : g_sel
      if (g < mcs_pkg::PRI_SECTORS) begin : g_pri
        assign sel[g] = |pri_terms[g*mcs_pkg::TERMS +: mcs_pkg::TERMS];
      end else begin : g_boot
        assign sel[g] = |boot_terms[(g-mcs_pkg::PRI_SECTORS)*mcs_pkg::TERMS +:
                                    mcs_pkg::TERMS];
      end
    end
  endgenerate
  assign prot = {boot_prot_q, pri_prot_q};

  // array input gating, access steering
  logic [7:0] addr_src;
  logic [4:0] map_eff;
  logic sram_sel;
  assign sram_sel = |sram_terms;
  assign addr_src = sep_mode_q ? {pins.muxed_bus_upper_nibble, pins.port_f_low_pins}
                               : pins.low_addr;
  assign map_eff = sep_mode_q ? mapping_q[4:0] : 5'h1F;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      array_in <= '0;
      access_en <= '0;
      sram_program_strobe <= 1'b0;
      boot_program_strobe <= 1'b0;
      port_f_peripheral_en <= 1'b0;
      primary_sector_selects <= '0;
      boot_sector_selects <= '0;
      sram_select <= 1'b0;
    end else begin
      array_in.low_address_gate <= gating_q[mcs_pkg::GT_ADDR_BIT] ? 8'h00 : addr_src;
      array_in.bus_control_inputs <= pins.bus_control_inputs &
          ~gating_q[mcs_pkg::GT_CNTL_LSB +: 3];
      array_in.ale <= pins.ale & ~gating_q[mcs_pkg::GT_ALE_BIT];
      array_in.high_byte_write_strobe <= pins.high_byte_write_strobe &
          ~gating_q[mcs_pkg::GT_WRH_BIT];
      access_en <= map_eff;
      sram_program_strobe <= !pins.program_store_strobe_n && sram_sel &&
                             map_eff[0];
      boot_program_strobe <= !pins.program_store_strobe_n &&
                             (|sel[NSEC-1:mcs_pkg::PRI_SECTORS]) && map_eff[1];
      port_f_peripheral_en <= mapping_q[mcs_pkg::MAP_PERIPH_BIT];
      primary_sector_selects <= sel[mcs_pkg::PRI_SECTORS-1:0];
      boot_sector_selects <= sel[NSEC-1:mcs_pkg::PRI_SECTORS];
      sram_select <= sram_sel;
    end
  end

  // flash command engine; plain writes outside a sequence change nothing
  logic [NSEC-1:0] bank_q;
  logic [NSEC-1:0] erase_mask_q;
  logic sector_erase_q;
  logic [23:0] gap_q;
  logic [23:0] busy_q;
  logic [NSEC-1:0] bank_now;
  assign bank_now = (|sel[mcs_pkg::PRI_SECTORS-1:0]) ?
                    {{mcs_pkg::BOOT_SECTORS{1'b0}}, {mcs_pkg::PRI_SECTORS{1'b1}}} :
                    {{mcs_pkg::BOOT_SECTORS{1'b1}}, {mcs_pkg::PRI_SECTORS{1'b0}}};

  logic timed_out;
  logic waiting;
  assign waiting = state_q inside {[mcs_pkg::FS_UNL1:mcs_pkg::FS_ERS_UNL2]};
  assign timed_out = waiting && gap_q >= 24'(BYTE_TIMEOUT);
  assign refuse_ev = flash_wr && state_q == mcs_pkg::FS_PROG_DATA &&
                     |(sel & prot) ||
                     state_q == mcs_pkg::FS_SE_WIN && gap_q >= 24'(SE_WINDOW) &&
                     erase_mask_q == '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q <= 24'h000000;
    end else if (flash_wr || !(waiting || state_q == mcs_pkg::FS_SE_WIN)) begin
      gap_q <= 24'h000000;
    end else begin
      gap_q <= gap_q + 24'h000001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= mcs_pkg::FS_READ;
      bank_q <= '0;
      erase_mask_q <= '0;
      sector_erase_q <= 1'b0;
      busy_q <= '0;
    end else if (timed_out) begin
      state_q <= mcs_pkg::FS_READ;
    end else begin
      case (state_q)
        mcs_pkg::FS_READ: begin
          if (flash_wr && (|sel) && is_cmd(flash_addr, flash_data,
              mcs_pkg::UNLOCK_ADDR1, mcs_pkg::CODE_UNLOCK1)) begin
            state_q <= mcs_pkg::FS_UNL1;
            bank_q <= bank_now;
          end
        end
        mcs_pkg::FS_UNL1: begin
          if (flash_wr) begin
            state_q <= is_cmd(flash_addr, flash_data, mcs_pkg::UNLOCK_ADDR2,
                       mcs_pkg::CODE_UNLOCK2) ? mcs_pkg::FS_UNL2 : mcs_pkg::FS_READ;
          end
        end
        mcs_pkg::FS_UNL2: begin
          if (flash_wr) begin
            if (flash_addr != mcs_pkg::UNLOCK_ADDR1) begin
              state_q <= mcs_pkg::FS_READ;
            end else if (flash_data == mcs_pkg::CODE_PROGRAM) begin
              state_q <= mcs_pkg::FS_PROG_DATA;
            end else if (flash_data == mcs_pkg::CODE_ERASE) begin
              state_q <= mcs_pkg::FS_ERS_CMD;
            end else if (flash_data == mcs_pkg::CODE_IDENT) begin
              state_q <= mcs_pkg::FS_IDENT;
            end else begin
              state_q <= mcs_pkg::FS_READ;
            end
          end
        end
        mcs_pkg::FS_PROG_DATA: begin
          if (flash_wr) begin
            if (|(sel & prot)) begin
              state_q <= mcs_pkg::FS_READ;
            end else begin
              state_q <= mcs_pkg::FS_BUSY;
              sector_erase_q <= 1'b0;
              busy_q <= 24'(PROG_TIME);
            end
          end
        end
        mcs_pkg::FS_ERS_CMD: begin
          if (flash_wr) begin
            state_q <= is_cmd(flash_addr, flash_data, mcs_pkg::UNLOCK_ADDR1,
                       mcs_pkg::CODE_UNLOCK1) ? mcs_pkg::FS_ERS_UNL1 : mcs_pkg::FS_READ;
          end
        end
        mcs_pkg::FS_ERS_UNL1: begin
          if (flash_wr) begin
            state_q <= is_cmd(flash_addr, flash_data, mcs_pkg::UNLOCK_ADDR2,
                       mcs_pkg::CODE_UNLOCK2) ? mcs_pkg::FS_ERS_UNL2 : mcs_pkg::FS_READ;
          end
        end
        mcs_pkg::FS_ERS_UNL2: begin
          if (flash_wr) begin
            if (flash_data == mcs_pkg::CODE_SECTOR) begin
              state_q <= mcs_pkg::FS_SE_WIN;
              erase_mask_q <= sel & ~prot;
            end else if (is_cmd(flash_addr, flash_data, mcs_pkg::UNLOCK_ADDR1,
                                mcs_pkg::CODE_BULK) && |(bank_q & ~prot)) begin
              state_q <= mcs_pkg::FS_BUSY;
              erase_mask_q <= bank_q & ~prot;
              sector_erase_q <= 1'b0;
              busy_q <= 24'(ERASE_TIME);
            end else begin
              state_q <= mcs_pkg::FS_READ;
            end
          end
        end
        mcs_pkg::FS_SE_WIN: begin
          if (flash_wr && flash_data == mcs_pkg::CODE_SECTOR) begin
            erase_mask_q <= erase_mask_q | (sel & ~prot);
          end else if (flash_wr) begin
            state_q <= mcs_pkg::FS_READ;
            erase_mask_q <= '0;
          end else if (gap_q >= 24'(SE_WINDOW)) begin
            state_q <= (erase_mask_q == '0) ? mcs_pkg::FS_READ : mcs_pkg::FS_BUSY;
            sector_erase_q <= 1'b1;
            busy_q <= 24'(ERASE_TIME);
          end
        end
        mcs_pkg::FS_BUSY: begin
          if (flash_wr && sector_erase_q && flash_data == mcs_pkg::CODE_SUSPEND) begin
            state_q <= mcs_pkg::FS_SUSP;
          end else if (busy_q <= 24'h000001) begin
            state_q <= mcs_pkg::FS_READ;
            erase_mask_q <= '0;
            busy_q <= '0;
          end else begin
            busy_q <= busy_q - 24'h000001;
          end
        end
        mcs_pkg::FS_SUSP: begin
          if (flash_wr && flash_data == mcs_pkg::CODE_SECTOR) begin
            state_q <= mcs_pkg::FS_BUSY;
          end
        end
        mcs_pkg::FS_IDENT: begin
          if (flash_wr && flash_data == mcs_pkg::CODE_RESET) begin
            state_q <= mcs_pkg::FS_READ;
          end
        end
        default: state_q <= mcs_pkg::FS_READ;
      endcase
    end
  end

  // host polls this before the next operation
  assign ready_busy_pin = (state_q != mcs_pkg::FS_BUSY);
endmodule // mcs_memory_config
`default_nettype wire

// File: test/mcs_chk.sv
// checker: port assertions of the memory config block
`timescale 1ns/1ns
`default_nettype none
module mcs_chk #(
  parameter logic [7:0] ID_A = 8'h00,
  parameter logic [7:0] ID_B = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire mcs_pkg::mcs_pins_t pins_in,
  input wire logic [23:0] pri_terms,
  input wire logic [11:0] boot_terms,
  input wire logic [2:0] sram_terms,
  input wire logic flash_wr,
  input wire mcs_pkg::mcs_array_in_t array_in,
  input wire logic port_f_peripheral_en,
  input wire logic [7:0] primary_sector_selects,
  input wire logic [3:0] boot_sector_selects,
  input wire logic sram_select,
  input wire logic ready_busy_pin
);
  logic [7:0] ra_q;
  logic [7:0] gap_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  function automatic logic [12:0] ors(logic [23:0] p, logic [11:0] b, logic [2:0] s);
    ors[0] = |s;
    for (int i = 0; i < 8; i++) ors[5+i] = |p[3*i+:3];
    for (int i = 0; i < 4; i++) ors[1+i] = |b[3*i+:3];
  endfunction
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) ra_q <= 8'h00;
    else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  // cycles since last flash write
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) gap_q <= 8'hFF;
    else gap_q <= flash_wr ? 8'h00 : gap_q + {7'h0, gap_q != 8'hFF};
  a_sel_terms: assert property ($past(rst_n) |->
    {primary_sector_selects, boot_sector_selects, sram_select} ==
    ors($past(pri_terms), $past(boot_terms), $past(sram_terms))) else $error("select");
  a_addr_src: assert property (array_in.low_address_gate != 8'h00 |->
    array_in.low_address_gate == $past(pins_in.low_addr, 3)) else $error("addr gate");
  a_rdata_hi: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("rdata high");
  a_ident_a: assert property (s_axi_rvalid && ra_q == mcs_pkg::OFS_IDENT_A |->
    s_axi_rdata[7:0] == ID_A) else $error("ident a");
  a_ident_b: assert property (s_axi_rvalid && ra_q == mcs_pkg::OFS_IDENT_B |->
    s_axi_rdata[7:0] == ID_B) else $error("ident b");
  a_busy_cause: assert property ($fell(ready_busy_pin) |-> gap_q < 8'd28)
    else $error("busy cause");
  a_busy_ends: assert property ($fell(ready_busy_pin) |-> ##[1:45] ready_busy_pin)
    else $error("busy end");
  a_periph_rst: assert property ($rose(rst_n) |-> !port_f_peripheral_en)
    else $error("periph rst");
  c_busy: cover property ($fell(ready_busy_pin));
  c_ident: cover property (s_axi_rvalid && ra_q == mcs_pkg::OFS_IDENT_A);
  c_gate: cover property (array_in.low_address_gate != 8'h00);
endmodule // mcs_chk
bind mcs_memory_config mcs_chk #(.ID_A({SRAM_SIZE, PRI_SIZE}), .ID_B({2'h0, SEC_TYPE, SEC_SIZE}))
  u_chk (.*);
`default_nettype wire

// File: test/mcs_host_model.sv
// host model: byte writes and coded commands on the flash bus
`timescale 1ns/1ns
`default_nettype none
module mcs_host_model (
  input wire logic clk,
  output var logic flash_wr,
  output var logic [11:0] flash_addr,
  output var logic [7:0] flash_data
);
  initial {flash_wr, flash_addr, flash_data} = '0;
  // two edges a byte, well inside the byte time-out
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    {flash_wr, flash_addr, flash_data} <= {1'b1, a, d};
    @(posedge clk);
    {flash_wr, flash_data} <= {1'b0, ~d};
  endtask
  task automatic cmd(input logic [7:0] c);
    wr(mcs_pkg::UNLOCK_ADDR1, mcs_pkg::CODE_UNLOCK1);
    wr(mcs_pkg::UNLOCK_ADDR2, mcs_pkg::CODE_UNLOCK2);
    wr(mcs_pkg::UNLOCK_ADDR1, c);
  endtask
endmodule // mcs_host_model
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench of the memory config block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk, rst_n, awv, wv, br, arv, rr, awr, wrd, bv, arr, rv, fwr, pfe, rb, sps, bps;
  logic [7:0] awa, ara, g, m, fd;
  logic [31:0] wd, rdat, rd;
  logic [1:0] bresp, rresp, rsp;
  logic [23:0] pt;
  logic [11:0] bt, fa;
  logic [2:0] st;
  mcs_pkg::mcs_pins_t pins;
  mcs_pkg::mcs_array_in_t ai;
  mcs_pkg::mcs_access_t acc;
  int err_count, compares, seed;
  mcs_memory_config #(.SE_WINDOW(20), .BYTE_TIMEOUT(16), .PROG_TIME(8), .ERASE_TIME(30)) DUT (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .pins_in(pins), .pri_terms(pt), .boot_terms(bt),
    .sram_terms(st), .flash_wr(fwr), .flash_addr(fa), .flash_data(fd), .array_in(ai),
    .access_en(acc), .sram_program_strobe(sps), .boot_program_strobe(bps),
    .port_f_peripheral_en(pfe), .primary_sector_selects(), .boot_sector_selects(),
    .sram_select(), .ready_busy_pin(rb));
  mcs_host_model host (.clk(clk), .flash_wr(fwr), .flash_addr(fa), .flash_data(fd));
  task automatic summarize();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {awa, wd, awv, wv, br} <= {a, 24'h0, d, 3'h7};
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv);
    br <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    {ara, arv, rr} <= {a, 2'h3};
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rr <= 1'b0;
    {rd, rsp} = {rdat, rresp};
  endtask
  // wait for ready level, compare
  task automatic wt(input logic v, input int lim);
    int n;
    n = 0;
    while (rb !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    ck(32'(rb), 32'(v));
  endtask
  function automatic logic [12:0] exp_ai(logic [7:0] gt, mcs_pkg::mcs_pins_t p);
    return {gt[0] ? 8'h00 : p.low_addr, p.bus_control_inputs & ~gt[4:2],
      p.ale & ~gt[5], p.high_byte_write_strobe & ~gt[6]};
  endfunction
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #300000;
    err_count++;
    summarize();
  end
  initial begin
    seed = 29;
    rst_n = 1'b0;
    {awv, wv, br, arv, rr} = '0;
    {awa, ara, wd, pt, bt, st, pins} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    axr(mcs_pkg::OFS_MAPPING);
    ck(rd, 32'h0);
    axw(mcs_pkg::OFS_IDENT_A, 8'hFF);
    axr(mcs_pkg::OFS_IDENT_A);
    ck(rd, {24'h0, mcs_pkg::SRAM_SIZE_CODE, mcs_pkg::PRI_SIZE_CODE});
    axr(mcs_pkg::OFS_IDENT_B);
    ck(rd, {26'h0, mcs_pkg::SEC_TYPE_CODE, mcs_pkg::SEC_SIZE_CODE});
    axr(8'h40);
    ck(32'(rsp), 32'(mcs_pkg::RESP_SLVERR));
    for (int i = 0; i < 12; i++) begin
      g = (i == 0) ? 8'hFF : 8'($random(seed));
      m = (i == 0) ? 8'hFF : 8'($random(seed));
      axw(mcs_pkg::OFS_GATING, g);
      axw(mcs_pkg::OFS_MAPPING, m);
      // strap stays low
      pins <= mcs_pkg::mcs_pins_t'(23'($random(seed)) & 23'h7FFFFE);
      {pt, bt, st} <= {24'($random(seed)), 12'($random(seed)), 3'($random(seed))};
      repeat (5) @(posedge clk);
      ck(32'(ai), 32'(exp_ai(g, pins)));
      ck(32'(pfe), 32'(m[7]));
      ck(32'(acc), 32'h1F);
      ck(32'(sps), 32'(!pins.program_store_strobe_n && (|st)));
      ck(32'(bps), 32'(!pins.program_store_strobe_n && (|bt)));
      axr(mcs_pkg::OFS_GATING);
      ck(rd, {24'h0, g & mcs_pkg::GATING_MASK});
      axr(mcs_pkg::OFS_MAPPING);
      ck(rd, {24'h0, m & mcs_pkg::MAPPING_MASK});
    end
    {pt, bt, st} <= {24'h000001, 15'h0};
    host.cmd(mcs_pkg::CODE_PROGRAM);
    host.wr(12'h010, 8'($random(seed)));
    wt(1'b0, 4);
    wt(1'b1, 20);
    axw(mcs_pkg::OFS_PRI_PROT, 8'h01);
    host.cmd(mcs_pkg::CODE_PROGRAM);
    host.wr(12'h010, 8'h5A);
    repeat (4) @(posedge clk);
    ck(32'(rb), 32'h1);
    axr(mcs_pkg::OFS_STATUS);
    ck(32'(rd[4]), 32'h1);
    axw(mcs_pkg::OFS_PRI_PROT, 8'h00);
    // bad byte, time-out, bad address
    for (int k = 0; k < 3; k++) begin
      host.wr(mcs_pkg::UNLOCK_ADDR1, mcs_pkg::CODE_UNLOCK1);
      host.wr(mcs_pkg::UNLOCK_ADDR2, k == 0 ? 8'h56 : mcs_pkg::CODE_UNLOCK2);
      if (k == 1) repeat (20) @(posedge clk);
      host.wr(k == 2 ? 12'h010 : mcs_pkg::UNLOCK_ADDR1, mcs_pkg::CODE_PROGRAM);
      host.wr(12'h010, 8'h3C);
      repeat (4) @(posedge clk);
      ck(32'(rb), 32'h1);
    end
    host.cmd(mcs_pkg::CODE_ERASE);
    host.cmd(mcs_pkg::CODE_SECTOR);
    wt(1'b0, 30);
    host.wr(12'h000, mcs_pkg::CODE_SUSPEND);
    wt(1'b1, 4);
    host.wr(12'h000, mcs_pkg::CODE_SECTOR);
    wt(1'b0, 4);
    wt(1'b1, 40);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
